// ==== hw/scclc_clock_loop.sv ====
// Serial channel clock routing, loop, underrun and baud generator control
// Functional notes
// - underrun sends abort+flag if selected, else CRC
// - closing start sets status; end signals buffer empty
// - abort plus mark idle sends continuous ones
// - abort select ignored in loop; reset clears
// - go on-loop after poll enable and end-of-poll
// - loop disabled on-loop leaves at next end-of-poll
// - char loop holds marking until sync, then transmits
// - loop for 6/8/16 sync, ignored async, reset
// - short sync in mono gives six-bit sync
// - short sync bisync: receive 12, transmit 16
// - crystal enables oscillator, forces sync zero
// - receive clock four-way source, reset bidirectional pin
// - transmit clock same encoding, reset bidirectional pin
// - FM transmit recovered clock lags ninety degrees
// - bidirectional pin output only when enabled, unused
// - pin output source four-way, reset oscillator
// - oscillator echo without crystal drives pin high
// - new divisor used at next reload only
// - count down to zero, reload cycle, toggle
// - disable immediate, enable after two counts
// - mark idle sends ones after closing flag
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "scclc_defs.svh"
module scclc_clock_loop #(
	parameter int ADDR_W = 5 // AXI address width
) (
	input wire logic core_clk, // Core clock
	input wire logic srst, // Hardware reset
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic primaryClkPin, // Primary clock pin
	input wire logic xtalOscIn, // Crystal amplifier output
	input wire logic syncPinIn, // Sync pin
	input wire logic bidirClkIn, // Bidirectional clock pin in
	output logic bidirClkOut, // Bidirectional clock pin out
	output logic bidirClkOe, // Bidirectional clock pin drive
	input wire logic [1:0] recPhase, // Recovered clock phase count
	input wire logic txUnderrun, // Transmit underrun pulse
	input wire logic txCharEnd, // Transmit char boundary pulse
	input wire logic closeFlagDone, // Closing flag sent pulse
	input wire logic syncSeen, // Sync character received pulse
	input wire logic endOfPoll, // End-of-poll received pulse
	output logic xtalEnable, // Crystal oscillator on
	output logic syncInternal, // Internal sync signal
	output logic rxClk, // Selected receive clock
	output logic txClk, // Selected transmit clock
	output logic baudOut, // Baud generator output
	output scclc_pkg::scclc_close_t txCloseSel, // Closing kind
	output logic txCloseBusy, // Closing sequence running
	output logic txIdleMarks, // Idle with ones, not flags
	output logic underrunEom, // Underrun/end-of-message status
	output logic extStatusEvt, // External/status event pulse
	output logic txEmptyEvt, // Transmit buffer empty pulse
	output logic onLoop, // Channel on-loop
	output logic loopBypass, // Receive data passed straight
	output logic txLoopEnable, // Transmitter released in loop
	output logic txMarkHold, // Hold transmit data marking
	output logic txBreak, // Break on transmit data
	output scclc_pkg::scclc_sync_t syncLen // Sync lengths
);
	import scclc_pkg::*;
	// ==========================================
	// Register file
	logic [4:0] lineCtl;
	scclc_route_t route;
	logic [7:0] bdLo;
	logic [7:0] bdHi;
	logic [1:0] miscCtl;
	logic [3:0] modeCfg;
	scclc_mode_t mode;
	scclc_loop_t loopSt;
	logic chanRst;
	logic eomClr;
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic wLane;
	logic doWrite;
	// Decodes a mapped register offset
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic m;
		m = 1'b0;
		if (a == `SCCLC_OFS_LINE) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_ROUTE) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_BDLO) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_BDHI) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_MISC) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_MODE) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_STAT) begin
			m = 1'b1;
		end else if (a == `SCCLC_OFS_CMD) begin
			m = 1'b1;
		end
		return m;
	endfunction
	assign mode = scclc_mode_t'(modeCfg[1:0]);
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	// Write address and data taken in either order
	always_ff @(posedge core_clk) begin
		if (srst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wLane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SCCLC_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wLane <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= isMapped(awAddr) ? `SCCLC_RESP_OK : `SCCLC_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Ready flags for the two write channels
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
		end
	end
	// Control registers; channel reset clears line control
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lineCtl <= '0;
			route <= scclc_route_t'(`SCCLC_RST_ROUTE);
			bdLo <= '0;
			bdHi <= '0;
			miscCtl <= '0;
			modeCfg <= '0;
		end else if (chanRst) begin
			lineCtl <= '0;
		end else if (doWrite && wLane) begin
			if (awAddr == `SCCLC_OFS_LINE) begin
				lineCtl <= wData[4:0];
			end else if (awAddr == `SCCLC_OFS_ROUTE) begin
				route <= scclc_route_t'(wData[7:0]);
			end else if (awAddr == `SCCLC_OFS_BDLO) begin
				bdLo <= wData[7:0];
			end else if (awAddr == `SCCLC_OFS_BDHI) begin
				bdHi <= wData[7:0];
			end else if (awAddr == `SCCLC_OFS_MISC) begin
				miscCtl <= wData[1:0];
			end else if (awAddr == `SCCLC_OFS_MODE) begin
				modeCfg <= wData[3:0];
			end
		end
	end
	// Command strobes: channel reset and status clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			chanRst <= 1'b0;
			eomClr <= 1'b0;
		end else begin
			chanRst <= doWrite && wLane && awAddr == `SCCLC_OFS_CMD
				&& wData[`SCCLC_B_CHRST];
			eomClr <= doWrite && wLane && awAddr == `SCCLC_OFS_STAT
				&& wData[`SCCLC_B_EOMCLR];
		end
	end
	// Read channel
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `SCCLC_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= isMapped(s_axi_araddr) ? `SCCLC_RESP_OK : `SCCLC_RESP_ERR;
				s_axi_rdata <= '0;
				if (s_axi_araddr == `SCCLC_OFS_LINE) begin
					s_axi_rdata[4:0] <= lineCtl;
				end else if (s_axi_araddr == `SCCLC_OFS_ROUTE) begin
					s_axi_rdata[7:0] <= route;
				end else if (s_axi_araddr == `SCCLC_OFS_BDLO) begin
					s_axi_rdata[7:0] <= bdLo;
				end else if (s_axi_araddr == `SCCLC_OFS_BDHI) begin
					s_axi_rdata[7:0] <= bdHi;
				end else if (s_axi_araddr == `SCCLC_OFS_MISC) begin
					s_axi_rdata[1:0] <= miscCtl;
				end else if (s_axi_araddr == `SCCLC_OFS_MODE) begin
					s_axi_rdata[3:0] <= modeCfg;
				end else if (s_axi_araddr == `SCCLC_OFS_STAT) begin
					s_axi_rdata[5:0] <= {loopSt, txLoopEnable, txCloseBusy, onLoop, underrunEom};
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ==========================================
	// Pin synchronisers and edge finders
	localparam int NPIN = 6;
	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] pinMeta;
	logic [NPIN-1:0] pinSync;
	logic [NPIN-1:0] pinLast;
	assign pinRaw = {syncPinIn, xtalOscIn, recPhase, bidirClkIn, primaryClkPin};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			// Two stages, then a history stage for edges
			always_ff @(posedge core_clk) begin
				if (srst) begin
					pinMeta[gi] <= 1'b0;
					pinSync[gi] <= 1'b0;
					pinLast[gi] <= 1'b0;
				end else begin
					pinMeta[gi] <= pinRaw[gi];
					pinSync[gi] <= pinMeta[gi];
					pinLast[gi] <= pinSync[gi];
				end
			end
		end
	endgenerate
	// ==========================================
	// Clock source selection
	logic priSrc;
	logic priPrev;
	logic recRx;
	logic recTx;
	logic next_rxClk;
	logic next_txClk;
	logic next_pinOut;
	logic next_pinOe;
	// Crystal replaces the primary pin as source; recovered tx lags in FM
	always_comb begin
		priSrc = route.xtal ? pinSync[4] : pinSync[0];
		priPrev = route.xtal ? pinLast[4] : pinLast[0];
		recRx = pinSync[3];
		recTx = modeCfg[`SCCLC_B_FM] ? !(pinSync[3] ^ pinSync[2]) : recRx;
	end
	// Selects a clock by the shared four-way code
	function automatic logic pickClk(input logic [1:0] s, input logic p,
		input logic b, input logic g, input logic r);
		logic c;
		c = p;
		case (s)
			`SCCLC_SRC_BIDIR: c = b;
			`SCCLC_SRC_BAUD: c = g;
			`SCCLC_SRC_REC: c = r;
			default: c = p;
		endcase
		return c;
	endfunction
	// Receive, transmit and pin source muxes
	always_comb begin
		next_rxClk = pickClk(route.rxSrc, priSrc, pinSync[1], baudOut, recRx);
		next_txClk = pickClk(route.txSrc, priSrc, pinSync[1], baudOut, recTx);
		next_pinOe = route.pinOe && route.rxSrc != `SCCLC_SRC_BIDIR
			&& route.txSrc != `SCCLC_SRC_BIDIR;
		next_pinOut = pickClk(route.pinSrc, route.xtal ? pinSync[4] : 1'b1,
			next_txClk, baudOut, recRx);
	end
	// Clock outputs and crystal control
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxClk <= 1'b0;
			txClk <= 1'b0;
			bidirClkOut <= 1'b0;
			bidirClkOe <= 1'b0;
			xtalEnable <= 1'b0;
			syncInternal <= 1'b0;
		end else begin
			rxClk <= next_rxClk;
			txClk <= next_txClk;
			bidirClkOut <= next_pinOe ? next_pinOut : 1'b0;
			bidirClkOe <= next_pinOe;
			xtalEnable <= route.xtal;
			syncInternal <= route.xtal ? 1'b0 : pinSync[5];
		end
	end
	// ==========================================
	// Baud rate generator
	logic [15:0] baudCnt;
	logic baudReload;
	logic [1:0] enCnt;
	logic baudTick;
	logic baudRun;
	assign baudTick = miscCtl[`SCCLC_B_BDSRC] || (priSrc && !priPrev);
	assign baudRun = miscCtl[`SCCLC_B_BDEN] && enCnt == `SCCLC_EN_COUNTS;
	// Enable shows after two source counts, disable at once
	always_ff @(posedge core_clk) begin
		if (srst || !miscCtl[`SCCLC_B_BDEN]) begin
			enCnt <= '0;
		end else if (baudTick && enCnt != `SCCLC_EN_COUNTS) begin
			enCnt <= enCnt + 2'h1;
		end
	end
	// Down counter, reload cycle, toggle stage
	always_ff @(posedge core_clk) begin
		if (srst) begin
			baudCnt <= '0;
			baudReload <= 1'b1;
			baudOut <= 1'b0;
		end else if (baudRun && baudTick) begin
			if (baudReload) begin
				baudCnt <= {bdHi, bdLo};
				baudReload <= 1'b0;
			end else if (baudCnt == 16'h0000) begin
				baudOut <= !baudOut;
				baudReload <= 1'b1;
			end else begin
				baudCnt <= baudCnt - 16'h0001;
			end
		end
	end
	// ==========================================
	// Underrun closing sequence
	logic txEdge;
	logic [4:0] closeCnt;
	logic closeStart;
	logic loopActive;
	assign txEdge = next_txClk && !txClk;
	assign loopActive = loopSt != SCCLC_LP_IDLE;
	assign closeStart = txUnderrun && mode == SCCLC_BITSYNC && !txCloseBusy;
	// Picks and times the 16-bit closing sequence
	always_ff @(posedge core_clk) begin
		if (srst) begin
			txCloseSel <= SCCLC_CL_CRC;
			txCloseBusy <= 1'b0;
			closeCnt <= '0;
			txEmptyEvt <= 1'b0;
			extStatusEvt <= 1'b0;
		end else begin
			txEmptyEvt <= 1'b0;
			extStatusEvt <= closeStart;
			if (closeStart) begin
				txCloseBusy <= 1'b1;
				closeCnt <= '0;
				if (loopActive || !lineCtl[`SCCLC_B_ABORT]) begin
					txCloseSel <= SCCLC_CL_CRC;
				end else if (lineCtl[`SCCLC_B_MARK]) begin
					txCloseSel <= SCCLC_CL_MARKS;
				end else begin
					txCloseSel <= SCCLC_CL_ABORT;
				end
			end else if (txCloseBusy && txEdge) begin
				closeCnt <= closeCnt + 5'h01;
				if (closeCnt == `SCCLC_CLOSE_BITS - 5'h01) begin
					txCloseBusy <= 1'b0;
					txEmptyEvt <= 1'b1;
				end
			end
		end
	end
	// Sticky status, set wins over clear
	always_ff @(posedge core_clk) begin
		if (srst || chanRst) begin
			underrunEom <= 1'b0;
		end else if (closeStart) begin
			underrunEom <= 1'b1;
		end else if (eomClr) begin
			underrunEom <= 1'b0;
		end
	end
	// Idle after a closing flag: ones or flags
	always_ff @(posedge core_clk) begin
		if (srst || chanRst) begin
			txIdleMarks <= 1'b0;
		end else if (closeFlagDone) begin
			txIdleMarks <= lineCtl[`SCCLC_B_MARK] && !loopActive;
		end
	end
	// ==========================================
	// Loop mode control
	logic loopEn;
	logic charPend;
	assign loopEn = lineCtl[`SCCLC_B_LOOP] && mode != SCCLC_ASYNC;
	// Loop state machine
	always_ff @(posedge core_clk) begin
		if (srst || chanRst) begin
			loopSt <= SCCLC_LP_IDLE;
			charPend <= 1'b0;
		end else begin
			case (loopSt)
				SCCLC_LP_IDLE: begin
					if (loopEn) begin
						loopSt <= SCCLC_LP_SEARCH;
					end
				end
				SCCLC_LP_SEARCH: begin
					if (!loopEn) begin
						loopSt <= SCCLC_LP_IDLE;
					end else if (mode == SCCLC_BITSYNC) begin
						if (lineCtl[`SCCLC_B_POLL] && endOfPoll) begin
							loopSt <= SCCLC_LP_ON;
						end
					end else if (charPend && txCharEnd) begin
						loopSt <= SCCLC_LP_ON;
						charPend <= 1'b0;
					end else if (syncSeen && lineCtl[`SCCLC_B_POLL]) begin
						charPend <= 1'b1;
					end
				end
				SCCLC_LP_ON: begin
					if (!loopEn) begin
						loopSt <= mode == SCCLC_BITSYNC ? SCCLC_LP_LEAVE : SCCLC_LP_IDLE;
					end
				end
				default: begin
					if (endOfPoll) begin
						loopSt <= SCCLC_LP_IDLE;
					end
				end
			endcase
		end
	end
	// Loop outputs
	always_ff @(posedge core_clk) begin
		if (srst) begin
			onLoop <= 1'b0;
			loopBypass <= 1'b0;
			txLoopEnable <= 1'b0;
			txMarkHold <= 1'b0;
			txBreak <= 1'b0;
		end else begin
			onLoop <= loopSt == SCCLC_LP_ON || loopSt == SCCLC_LP_LEAVE;
			loopBypass <= loopSt == SCCLC_LP_SEARCH && mode == SCCLC_BITSYNC;
			txLoopEnable <= loopSt == SCCLC_LP_ON || loopSt == SCCLC_LP_LEAVE;
			txMarkHold <= loopSt == SCCLC_LP_SEARCH && mode != SCCLC_BITSYNC
				&& !modeCfg[`SCCLC_B_BRK];
			txBreak <= modeCfg[`SCCLC_B_BRK] && loopSt != SCCLC_LP_ON;
		end
	end
	// ==========================================
	// Sync character lengths
	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncLen <= '{rxLen: `SCCLC_SYNC8, txLen: `SCCLC_SYNC8};
		end else if (mode == SCCLC_BISYNC) begin
			syncLen.rxLen <= lineCtl[`SCCLC_B_SHORT] ? `SCCLC_SYNC12 : `SCCLC_SYNC16;
			syncLen.txLen <= `SCCLC_SYNC16;
		end else begin
			syncLen.rxLen <= lineCtl[`SCCLC_B_SHORT] && mode == SCCLC_MONO
				? `SCCLC_SYNC6 : `SCCLC_SYNC8;
			syncLen.txLen <= lineCtl[`SCCLC_B_SHORT] && mode == SCCLC_MONO
				? `SCCLC_SYNC6 : `SCCLC_SYNC8;
		end
	end
	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_close_crc: assert property (closeStart && !lineCtl[`SCCLC_B_ABORT]
		|=> txCloseSel == SCCLC_CL_CRC && txCloseBusy) else $error("crc not chosen");
	chk_close_marks: assert property (closeStart && !loopActive
		&& lineCtl[`SCCLC_B_ABORT] && lineCtl[`SCCLC_B_MARK]
		|=> txCloseSel == SCCLC_CL_MARKS) else $error("marks not chosen");
	chk_eom_event: assert property (closeStart && !chanRst
		|=> underrunEom && extStatusEvt ##1 !extStatusEvt) else $error("eom not raised");
	chk_loop_abort: assert property (closeStart && loopActive
		|=> txCloseSel == SCCLC_CL_CRC) else $error("abort used in loop");
	chk_go_loop: assert property (loopSt == SCCLC_LP_SEARCH && loopEn && !chanRst
		&& mode == SCCLC_BITSYNC && lineCtl[`SCCLC_B_POLL] && endOfPoll
		|=> ##1 onLoop) else $error("not on loop");
	chk_stay_loop: assert property (loopSt == SCCLC_LP_LEAVE && !endOfPoll && !chanRst
		|=> ##1 onLoop) else $error("left loop early");
	chk_short_sync: assert property (mode == SCCLC_MONO && lineCtl[`SCCLC_B_SHORT]
		|=> syncLen.rxLen == `SCCLC_SYNC6) else $error("sync not six");
	chk_xtal_sync: assert property (route.xtal |=> !syncInternal)
		else $error("sync not forced");
	chk_pin_dir: assert property (route.rxSrc == `SCCLC_SRC_BIDIR
		|=> !bidirClkOe) else $error("pin driven as input");
	chk_baud_stop: assert property (!miscCtl[`SCCLC_B_BDEN]
		|=> $stable(baudCnt) && $stable(baudOut)) else $error("baud ran disabled");
	cov_close: cover property (closeStart ##[1:200] txEmptyEvt);
	cov_loop: cover property (onLoop ##[1:200] !onLoop);
	cov_baud: cover property ($changed(baudOut));
endmodule

// ==== hw/scclc_defs.svh ====
// Offsets, bit positions, reset values and counts for the clock and loop control
`ifndef SCCLC_DEFS_SVH
`define SCCLC_DEFS_SVH
// ==========================================
// Register byte offsets
`define SCCLC_OFS_LINE 5'h00
`define SCCLC_OFS_ROUTE 5'h04
`define SCCLC_OFS_BDLO 5'h08
`define SCCLC_OFS_BDHI 5'h0C
`define SCCLC_OFS_MISC 5'h10
`define SCCLC_OFS_MODE 5'h14
`define SCCLC_OFS_STAT 5'h18
`define SCCLC_OFS_CMD 5'h1C
// ==========================================
// Line control bit positions
`define SCCLC_B_SHORT 0
`define SCCLC_B_LOOP 1
`define SCCLC_B_ABORT 2
`define SCCLC_B_MARK 3
`define SCCLC_B_POLL 4
// Misc control, mode and command bits
`define SCCLC_B_BDEN 0
`define SCCLC_B_BDSRC 1
`define SCCLC_B_FM 2
`define SCCLC_B_BRK 3
`define SCCLC_B_CHRST 0
`define SCCLC_B_EOMCLR 0
// ==========================================
// Reset values and codes
`define SCCLC_RST_ROUTE 8'h28
`define SCCLC_SRC_PRI 2'h0
`define SCCLC_SRC_BIDIR 2'h1
`define SCCLC_SRC_BAUD 2'h2
`define SCCLC_SRC_REC 2'h3
`define SCCLC_RESP_OK 2'h0
`define SCCLC_RESP_ERR 2'h2
// ==========================================
// Counts
`define SCCLC_CLOSE_BITS 5'h10
`define SCCLC_EN_COUNTS 2'h2
`define SCCLC_SYNC6 5'h06
`define SCCLC_SYNC8 5'h08
`define SCCLC_SYNC12 5'h0C
`define SCCLC_SYNC16 5'h10
`endif

// ==== hw/scclc_pkg.sv ====
// Types shared by the clock and loop control block
package scclc_pkg;
	// ==========================================
	// Framing modes
	typedef enum logic [1:0] {
		SCCLC_ASYNC = 2'h0,
		SCCLC_MONO = 2'h1,
		SCCLC_BISYNC = 2'h2,
		SCCLC_BITSYNC = 2'h3
	} scclc_mode_t;
	// Loop states, Gray along search, on-loop, leaving
	typedef enum logic [1:0] {
		SCCLC_LP_IDLE = 2'h0,
		SCCLC_LP_SEARCH = 2'h1,
		SCCLC_LP_ON = 2'h3,
		SCCLC_LP_LEAVE = 2'h2
	} scclc_loop_t;
	// Closing sequence after an underrun
	typedef enum logic [1:0] {
		SCCLC_CL_CRC = 2'h0,
		SCCLC_CL_ABORT = 2'h1,
		SCCLC_CL_MARKS = 2'h2
	} scclc_close_t;
	// Clock routing control fields
	typedef struct packed {
		logic xtal;
		logic [1:0] rxSrc;
		logic [1:0] txSrc;
		logic pinOe;
		logic [1:0] pinSrc;
	} scclc_route_t;
	// Sync character lengths
	typedef struct packed {
		logic [4:0] rxLen;
		logic [4:0] txLen;
	} scclc_sync_t;
endpackage

// ==== test/scclc_line_model.sv ====
// Far-side model: line clock sources, crystal, sync pin and bidirectional clock pin
`timescale 1ns/1ps
module scclc_line_model (
	input wire logic bidirClkOut, // Block drive value
	input wire logic bidirClkOe, // Block drives the pin
	output logic primaryClkPin, // Primary clock pin
	output logic xtalOscIn, // Crystal amplifier output
	output logic syncPinIn, // Sync pin level
	output logic bidirClkIn, // Resolved bidirectional pin
	output logic [1:0] recPhase // Recovered clock phase
);
	// ==========================================
	// Free-running line clock, 80 ns, offset from the core edges
	logic linkClk;
	logic [1:0] phaseCnt = 2'h0;
	initial begin
		linkClk = 1'b0;
		#3;
		forever #40 linkClk = ~linkClk;
	end
	// Phase count steps once a line clock period
	always @(posedge linkClk) begin
		phaseCnt <= phaseCnt + 2'h1;
	end
	assign recPhase = phaseCnt;
	// Remote station drives the inverse clock unless the block owns the pin
	assign bidirClkIn = bidirClkOe ? bidirClkOut : ~linkClk;
	assign primaryClkPin = linkClk;
	assign xtalOscIn = linkClk;
	assign syncPinIn = 1'b1; // High so a forced zero is visible
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the clock and loop control block
`timescale 1ns/1ps
`include "scclc_defs.svh"
module tb;
	import scclc_pkg::*;
	localparam int LIM = 2000;
	logic core_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0, evts = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdData;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, recPhase, rdResp;
	logic primaryClkPin, xtalOscIn, syncPinIn, bidirClkIn, bidirClkOut, bidirClkOe, xtalEnable;
	logic syncInternal, rxClk, txClk, baudOut, txCloseBusy, txIdleMarks, underrunEom, b;
	logic extStatusEvt, txEmptyEvt, onLoop, loopBypass, txLoopEnable, txMarkHold, txBreak;
	scclc_close_t txCloseSel;
	scclc_sync_t syncLen;
	int bad_count = 0, compares = 0, p;
	logic [7:0] lc [4] = '{8'h00, 8'h04, 8'h0C, 8'h06};
	scclc_close_t ex [4] = '{SCCLC_CL_CRC, SCCLC_CL_ABORT, SCCLC_CL_MARKS, SCCLC_CL_CRC};
	// ==========================================
	// Block and far side
	scclc_clock_loop #(.ADDR_W(5)) i_dut (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.primaryClkPin, .xtalOscIn, .syncPinIn, .bidirClkIn, .bidirClkOut, .bidirClkOe,
		.recPhase, .txUnderrun(evts[4]), .txCharEnd(evts[3]), .closeFlagDone(evts[2]),
		.syncSeen(evts[1]), .endOfPoll(evts[0]), .xtalEnable, .syncInternal, .rxClk, .txClk,
		.baudOut, .txCloseSel, .txCloseBusy, .txIdleMarks, .underrunEom, .extStatusEvt,
		.txEmptyEvt, .onLoop, .loopBypass, .txLoopEnable, .txMarkHold, .txBreak, .syncLen);
	scclc_line_model i_line (.bidirClkOut, .bidirClkOe, .primaryClkPin, .xtalOscIn,
		.syncPinIn, .bidirClkIn, .recPhase);
	// Core clock, 8 ns
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	// ==========================================
	// Shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task timeout(input int n);
		if (n >= LIM) begin
			bad_count++;
			$display("BAD %0t wait expired", $time);
			print_verdict;
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < LIM);
		s_axi_bready <= 1'b0;
		timeout(n);
		chk(s_axi_bresp, `SCCLC_RESP_OK);
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	// Read one word; data and response taken at the edge rvalid is seen
	task rd(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < LIM);
		rdData = s_axi_rdata;
		rdResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		timeout(n);
		#1;
	endtask
	// Single-cycle event pulse; returns just after the capturing edge
	task pulse(input logic [4:0] v);
		@(posedge core_clk);
		evts <= v;
		@(posedge core_clk);
		evts <= 5'h00;
		#1;
	endtask
	task waitLink(input int d);
		int n;
		n = 0;
		while (primaryClkPin !== 1'b0 && n < LIM) begin @(posedge core_clk); n++; end
		while (primaryClkPin !== 1'b1 && n < LIM) begin @(posedge core_clk); n++; end
		timeout(n);
		repeat (d) @(posedge core_clk);
		#1;
	endtask
	task baudPeriod(output int q);
		int n, k;
		logic prev;
		n = 0;
		k = 0;
		q = 0;
		prev = baudOut;
		while (k < 2 && n < LIM) begin
			@(posedge core_clk);
			#1;
			n++;
			if (baudOut === 1'b1 && prev === 1'b0) begin
				q = (k == 0) ? n : n - q;
				k++;
			end
			prev = baudOut;
		end
		timeout(n);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(bidirClkOe, 1'b0);
		chk(xtalEnable, 1'b0);
		rd(`SCCLC_OFS_ROUTE);
		chk(rdData, {24'h0, `SCCLC_RST_ROUTE});
		chk(rdResp, `SCCLC_RESP_OK);
		waitLink(9);
		chk(rxClk, 1'b1);
		chk(txClk, 1'b1);
		wr(`SCCLC_OFS_ROUTE, 8'h0C);
		waitLink(4);
		chk(rxClk, 1'b1);
		chk(txClk, 1'b0);
		chk(bidirClkOe, 1'b0);
		wr(`SCCLC_OFS_ROUTE, 8'h54);
		chk(bidirClkOe, 1'b1);
		chk(bidirClkOut, 1'b1);
		// Crystal only echoed on the bidirectional pin here; the generator runs from the core clock
		wr(`SCCLC_OFS_ROUTE, 8'hD4);
		chk(xtalEnable, 1'b1);
		chk(syncInternal, 1'b0);
		// Divisor loaded with the generator stopped
		wr(`SCCLC_OFS_MISC, 8'h02);
		wr(`SCCLC_OFS_BDLO, 8'h03);
		wr(`SCCLC_OFS_BDHI, 8'h00);
		rd(`SCCLC_OFS_BDLO);
		chk(rdData, 32'h00000003);
		rd(5'h02);
		chk(rdResp, `SCCLC_RESP_ERR);
		chk(rdData, 32'h00000000);
		wr(`SCCLC_OFS_MISC, 8'h03);
		baudPeriod(p);
		chk(32'(p), 32'd10);
		wr(`SCCLC_OFS_MISC, 8'h02);
		b = baudOut;
		repeat (20) @(posedge core_clk);
		chk(baudOut, b);
		wr(`SCCLC_OFS_MISC, 8'h03);
		wr(`SCCLC_OFS_MODE, 8'h03);
		// Underrun closing kinds, the last with loop mode set
		for (int i = 0; i < 4; i++) begin
			wr(`SCCLC_OFS_STAT, 8'h01);
			wr(`SCCLC_OFS_LINE, lc[i]);
			pulse(5'h10);
			chk(txCloseSel, ex[i]);
			chk(underrunEom, 1'b1);
			chk(extStatusEvt, 1'b1);
			p = 0;
			while (txCloseBusy === 1'b1 && p < LIM) begin @(posedge core_clk); #1; p++; end
			timeout(p);
			chk(txEmptyEvt, 1'b1);
			pulse(5'h04);
			chk(txIdleMarks, i == 2);
		end
		chk(loopBypass, 1'b1);
		wr(`SCCLC_OFS_LINE, 8'h12);
		pulse(5'h01);
		@(posedge core_clk);
		#1;
		chk(onLoop, 1'b1);
		wr(`SCCLC_OFS_LINE, 8'h10);
		chk(onLoop, 1'b1);
		pulse(5'h01);
		@(posedge core_clk);
		#1;
		chk(onLoop, 1'b0);
		wr(`SCCLC_OFS_MODE, 8'h01);
		wr(`SCCLC_OFS_LINE, 8'h13);
		chk(txMarkHold, 1'b1);
		chk(syncLen, {`SCCLC_SYNC6, `SCCLC_SYNC6});
		wr(`SCCLC_OFS_MODE, 8'h09);
		chk(txBreak, 1'b1);
		chk(txMarkHold, 1'b0);
		pulse(5'h02);
		pulse(5'h08);
		@(posedge core_clk);
		#1;
		chk(txLoopEnable, 1'b1);
		chk(txMarkHold, 1'b0);
		chk(txBreak, 1'b0);
		wr(`SCCLC_OFS_MODE, 8'h02);
		chk(syncLen, {`SCCLC_SYNC12, `SCCLC_SYNC16});
		wr(`SCCLC_OFS_CMD, 8'h01);
		chk(txLoopEnable, 1'b0);
		chk(syncLen, {`SCCLC_SYNC16, `SCCLC_SYNC16});
		rd(`SCCLC_OFS_LINE);
		chk(rdData, 32'h00000000);
		print_verdict;
	end
endmodule
